/* include/fwlg_pkg.sv */
// Shared constants and carrier types for the flash write lock gate
package fwlg_pkg;
  // Register byte offsets
  localparam logic [3:0] FWLG_OFS_GATE = 4'h0;
  localparam logic [3:0] FWLG_OFS_CTRL = 4'h4;
  localparam logic [3:0] FWLG_OFS_STAT = 4'h8;
  localparam logic [3:0] FWLG_OFS_MASK = 4'hc;
  // Key values
  localparam logic [7:0] FWLG_KEY_FIRST = 8'ha5;
  localparam logic [7:0] FWLG_KEY_SECOND = 8'hf1;
  // Control register fields
  localparam int FWLG_CTRL_WRITE_BIT = 0;
  localparam int FWLG_CTRL_ERASE_BIT = 1;
  // Event status bits
  localparam int FWLG_EV_DONE = 0;
  localparam int FWLG_EV_PERMLOCK = 1;
  localparam int FWLG_EV_FLASHERR = 2;
  localparam int FWLG_EV_W = 3;
  // Reset values
  localparam logic [7:0] FWLG_GATE_RST = 8'h00;
  localparam logic [1:0] FWLG_CTRL_RST = 2'h0;
  localparam logic [2:0] FWLG_EV_RST = 3'h0;
  // Lock state codes as read back
  typedef enum logic [1:0] {
    FWLG_LOCKED = 2'h0,
    FWLG_FIRST_KEY = 2'h1,
    FWLG_UNLOCKED = 2'h2,
    FWLG_DISABLED = 2'h3
  } fwlg_lock_type;
  // Move write request from the core
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } fwlg_move_type;
  // Command to the flash array
  typedef struct packed {
    logic write;
    logic erase;
    logic [15:0] addr;
    logic [7:0] data;
  } fwlg_flash_cmd_type;
endpackage

/* src/fwlg_gate.sv */
// Flash write lock gate with AXI4-Lite register access
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// How it works
// - Keys 0xA5 then 0xF1 unlock flash
// - Relock after the operation completes
// - Wrong key write forces permanent lock
// - Flash access while locked refused, permanent lock
// - Permanent lock held until device reset
// - Non-0xA5 first write locks on purpose
// - Read returns lock state code bits 1:0
// - 8-bit gate register resets to zero
// - Write permit sends move writes to flash
// - Both permits erase the addressed page
// - No supply monitor means flash error reset
module fwlg_gate
  import fwlg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core move write port
  input wire fwlg_pkg::fwlg_move_type moveReq,
  output logic moveToData,
  // Flash array
  output fwlg_pkg::fwlg_flash_cmd_type flashCmd,
  input wire logic flashDone,
  // Supply monitor
  input wire logic supplyMonOn,
  input wire logic supplyMonReset,
  output logic flashErrReset,
  // Interrupt
  output logic irq
);
  import fwlg_pkg::*;

  typedef struct packed {
    logic awHeld;
    logic [3:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    fwlg_lock_type lock;
    logic busy;
    logic [1:0] ctrl;
    logic [FWLG_EV_W-1:0] evStat;
    logic [FWLG_EV_W-1:0] evMask;
    fwlg_flash_cmd_type cmd;
    logic toData;
    logic errReset;
    logic irq;
  } fwlg_state_type;

  fwlg_state_type st_r;
  fwlg_state_type st_nxt;
  logic [FWLG_EV_W-1:0] evSet;
  logic doWrite;
  logic [7:0] gateKey;
  logic [31:0] rdVal;

  always_comb
  begin
    st_nxt = st_r;
    evSet = '0;
    doWrite = st_r.awHeld && st_r.wHeld && !st_r.bValid;
    gateKey = st_r.wData[7:0];
    rdVal = 32'h0;
    st_nxt.cmd.write = 1'b0;
    st_nxt.cmd.erase = 1'b0;
    st_nxt.toData = 1'b0;
    st_nxt.errReset = 1'b0;
    // Address and data are taken independently, one of each outstanding
    st_nxt.awReady = !st_r.awHeld && !(s_axi_awvalid && st_r.awReady);
    st_nxt.wReady = !st_r.wHeld && !(s_axi_wvalid && st_r.wReady);
    if (s_axi_awvalid && st_r.awReady)
    begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wReady)
    begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    // Flash operation finishing; the done event is raised
    if (st_r.busy && flashDone)
    begin
      st_nxt.busy = 1'b0;
      if (st_r.lock == FWLG_UNLOCKED)
        st_nxt.lock = FWLG_LOCKED;
      evSet[FWLG_EV_DONE] = 1'b1;
    end
    if (moveReq.valid && !st_r.busy)
    begin
      if (!st_r.ctrl[FWLG_CTRL_WRITE_BIT])
        st_nxt.toData = 1'b1;
      else if (!(supplyMonOn && supplyMonReset))
      begin
        st_nxt.errReset = 1'b1;
        evSet[FWLG_EV_FLASHERR] = 1'b1;
      end
      // only an unlocked gate lets the operation through
      else if (st_r.lock == FWLG_UNLOCKED)
      begin
        st_nxt.busy = 1'b1;
        st_nxt.cmd.addr = moveReq.addr;
        st_nxt.cmd.data = moveReq.data;
        // page erase when both permits set
        if (st_r.ctrl[FWLG_CTRL_ERASE_BIT])
          st_nxt.cmd.erase = 1'b1;
        else
          st_nxt.cmd.write = 1'b1;
      end
      else
      begin
        st_nxt.lock = FWLG_DISABLED;
        evSet[FWLG_EV_PERMLOCK] = st_r.lock != FWLG_DISABLED;
      end
    end
    // Register write: both channels held, answer OKAY or SLVERR
    if (doWrite)
    begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp = 2'h0;
      unique case (st_r.awAddr)
        FWLG_OFS_GATE:
          if (st_r.wStrb[0])
          begin
            // a move refused in this same cycle wins
            if (st_nxt.lock == FWLG_DISABLED)
              st_nxt.lock = FWLG_DISABLED;
            else if (st_r.lock == FWLG_LOCKED && gateKey == FWLG_KEY_FIRST)
              st_nxt.lock = FWLG_FIRST_KEY;
            else if (st_r.lock == FWLG_FIRST_KEY && gateKey == FWLG_KEY_SECOND)
              st_nxt.lock = FWLG_UNLOCKED;
            else
            begin
              st_nxt.lock = FWLG_DISABLED;
              evSet[FWLG_EV_PERMLOCK] = st_r.lock != FWLG_DISABLED;
            end
          end
        FWLG_OFS_CTRL:
          if (st_r.wStrb[0])
            st_nxt.ctrl = st_r.wData[1:0];
        FWLG_OFS_STAT:
          if (st_r.wStrb[0])
            st_nxt.evStat = st_r.evStat & ~st_r.wData[FWLG_EV_W-1:0];
        FWLG_OFS_MASK:
          if (st_r.wStrb[0])
            st_nxt.evMask = st_r.wData[FWLG_EV_W-1:0];
        default:
          st_nxt.bResp = 2'h2;
      endcase
    end
    if (st_r.bValid && s_axi_bready)
      st_nxt.bValid = 1'b0;
    // Register read
    unique case (s_axi_araddr)
      FWLG_OFS_GATE: rdVal = {30'h0, st_r.lock};
      FWLG_OFS_CTRL: rdVal = {30'h0, st_r.ctrl};
      FWLG_OFS_STAT: rdVal = {29'h0, st_r.evStat};
      FWLG_OFS_MASK: rdVal = {29'h0, st_r.evMask};
      default: rdVal = 32'h0;
    endcase
    st_nxt.arReady = !st_r.rValid && !(s_axi_arvalid && st_r.arReady);
    if (s_axi_arvalid && st_r.arReady)
    begin
      st_nxt.rValid = 1'b1;
      st_nxt.rData = rdVal;
      st_nxt.rResp = (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= FWLG_OFS_MASK) ? 2'h0 : 2'h2;
    end
    else if (st_r.rValid && s_axi_rready)
      st_nxt.rValid = 1'b0;
    // Set wins over a clear in the same cycle
    st_nxt.evStat = st_nxt.evStat | evSet;
    st_nxt.irq = |(st_nxt.evStat & st_nxt.evMask);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_awready = st_r.awReady;
  assign s_axi_wready = st_r.wReady;
  assign s_axi_bvalid = st_r.bValid;
  assign s_axi_bresp = st_r.bResp;
  assign s_axi_arready = st_r.arReady;
  assign s_axi_rvalid = st_r.rValid;
  assign s_axi_rdata = st_r.rData;
  assign s_axi_rresp = st_r.rResp;
  assign flashCmd = st_r.cmd;
  assign moveToData = st_r.toData;
  assign flashErrReset = st_r.errReset;
  assign irq = st_r.irq;

  // Assertions guarding the lock sequence
  a_disabled_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    st_r.lock == FWLG_DISABLED |=> st_r.lock == FWLG_DISABLED)
    else $error("permanent lock left without reset");
  a_second_key: assert property (@(posedge clock) disable iff (!rst_n)
    st_r.lock == FWLG_UNLOCKED && !$past(st_r.busy && flashDone) |-> $past(st_r.lock) inside {FWLG_FIRST_KEY, FWLG_UNLOCKED})
    else $error("unlocked without first key");
  a_relock_done: assert property (@(posedge clock) disable iff (!rst_n)
    st_r.busy && flashDone && st_r.lock == FWLG_UNLOCKED |=> st_r.lock == FWLG_LOCKED)
    else $error("no relock after operation");
  a_bad_key: assert property (@(posedge clock) disable iff (!rst_n)
    doWrite && st_r.awAddr == FWLG_OFS_GATE && st_r.wStrb[0] && gateKey != FWLG_KEY_FIRST
    && gateKey != FWLG_KEY_SECOND |=> st_r.lock == FWLG_DISABLED)
    else $error("bad key did not lock");
  a_first_wrong: assert property (@(posedge clock) disable iff (!rst_n)
    doWrite && st_r.awAddr == FWLG_OFS_GATE && st_r.wStrb[0] && st_r.lock == FWLG_LOCKED
    && gateKey != FWLG_KEY_FIRST |=> st_r.lock == FWLG_DISABLED)
    else $error("non-first key did not lock");
  a_locked_access: assert property (@(posedge clock) disable iff (!rst_n)
    moveReq.valid && !st_r.busy && st_r.ctrl[0] && supplyMonOn && supplyMonReset
    && st_r.lock != FWLG_UNLOCKED |=> st_r.lock == FWLG_DISABLED && !flashCmd.write && !flashCmd.erase)
    else $error("locked access not refused");
  a_erase_page: assert property (@(posedge clock) disable iff (!rst_n)
    flashCmd.erase |-> $past(st_r.ctrl) == 2'h3 && !flashCmd.write)
    else $error("erase without both permits");
  a_flash_err: assert property (@(posedge clock) disable iff (!rst_n)
    moveReq.valid && !st_r.busy && st_r.ctrl[0] && !supplyMonOn |=> flashErrReset ##1 !flashErrReset)
    else $error("missing flash error reset");
  a_steer_data: assert property (@(posedge clock) disable iff (!rst_n)
    flashCmd.write |-> $past(st_r.ctrl[0]) && !moveToData)
    else $error("flash write without permit");
  a_twelve: assert property (@(posedge clock) disable iff (!rst_n)
    doWrite && st_r.awAddr == FWLG_OFS_GATE && st_r.wStrb[0] && st_r.lock == FWLG_UNLOCKED
    |=> st_r.lock == FWLG_DISABLED)
    else $error("extra key did not lock");
  // Events, pulses and bus answers
  a_done_status: assert property (@(posedge clock) disable iff (!rst_n)
    st_r.busy && flashDone |=> st_r.evStat[FWLG_EV_DONE])
    else $error("done event not recorded");
  a_permlock_event: assert property (@(posedge clock) disable iff (!rst_n)
    st_r.lock != FWLG_DISABLED ##1 st_r.lock == FWLG_DISABLED |-> st_r.evStat[FWLG_EV_PERMLOCK])
    else $error("permanent lock event not recorded");
  a_cmd_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    flashCmd.write || flashCmd.erase |=> !flashCmd.write && !flashCmd.erase)
    else $error("flash command longer than one cycle");
  a_move_data: assert property (@(posedge clock) disable iff (!rst_n)
    moveReq.valid && !st_r.busy && !st_r.ctrl[FWLG_CTRL_WRITE_BIT] |=> moveToData && !flashCmd.write && !flashCmd.erase)
    else $error("move without permit not sent to data memory");
  a_write_resp: assert property (@(posedge clock) disable iff (!rst_n)
    doWrite |=> s_axi_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (@(posedge clock) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_resp: assert property (@(posedge clock) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  c_unlock: cover property (@(posedge clock) disable iff (!rst_n)
    st_r.lock == FWLG_FIRST_KEY ##[1:20] st_r.lock == FWLG_UNLOCKED);
  c_write_done: cover property (@(posedge clock) disable iff (!rst_n)
    flashCmd.write ##[1:50] st_r.lock == FWLG_LOCKED);
  c_perm: cover property (@(posedge clock) disable iff (!rst_n) st_r.lock == FWLG_DISABLED);
  c_irq: cover property (@(posedge clock) disable iff (!rst_n) irq);
  c_erase: cover property (@(posedge clock) disable iff (!rst_n) flashCmd.erase);
endmodule

/* test/fwlg_gate_test.sv */
// Self-checking testbench for the flash write lock gate
`timescale 1ns/1ps
module fwlg_gate_test;
  import fwlg_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, moveToData, flashErrReset, irq;
  logic [1:0] bresp, rresp;
  fwlg_move_type moveReq = '0;
  fwlg_flash_cmd_type flashCmd;
  logic flashDone = 1'b0, supplyMonOn = 1'b1, supplyMonReset = 1'b1;
  logic [31:0] seed = 32'hde8ff342;
  logic [7:0] k;
  logic [3:0] got;
  fwlg_lock_type s;
  logic [1:0] lastResp = 2'h0;
  int failCount = 0;
  int cmpCount = 0;

  fwlg_gate u_dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .moveReq(moveReq),
    .moveToData(moveToData), .flashCmd(flashCmd), .flashDone(flashDone), .supplyMonOn(supplyMonOn),
    .supplyMonReset(supplyMonReset), .flashErrReset(flashErrReset), .irq(irq));

  initial
  begin
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic fwlg_lock_type nextLock(input fwlg_lock_type st, input logic [7:0] key);
    if (st == FWLG_LOCKED)
      return (key == FWLG_KEY_FIRST) ? FWLG_FIRST_KEY : FWLG_DISABLED;
    if (st == FWLG_FIRST_KEY)
      return (key == FWLG_KEY_SECOND) ? FWLG_UNLOCKED : FWLG_DISABLED;
    return FWLG_DISABLED;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e)
    begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic finalReport;
    $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, where registered readies are settled
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hb;
    n = 0;
    hb = 1'b0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb && n < 100)
    begin
      @(negedge clock);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      if (hb) lastResp = bresp;
      n++;
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    if (!hb)
    begin
      failCount++;
      $display("wrong value at %0t: write response timed out", $time);
    end
  endtask

  task automatic axiRd(input logic [3:0] a, output logic [31:0] d);
    int n;
    logic ha, hr;
    n = 0;
    hr = 1'b0;
    d = 32'h0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr && n < 100)
    begin
      @(negedge clock);
      ha = arvalid && arready;
      hr = rvalid && rready;
      if (hr) d = rdata;
      if (hr) lastResp = rresp;
      n++;
      @(posedge clock);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    if (!hr)
    begin
      failCount++;
      $display("wrong value at %0t: read response timed out", $time);
    end
  endtask

  task automatic gateIs(input fwlg_lock_type e);
    axiRd(FWLG_OFS_GATE, rd);
    chk(rd, {30'h0, e});
    chk({30'h0, lastResp}, 32'h0);
  endtask

  task automatic irqIs(input logic e);
    @(negedge clock);
    @(negedge clock);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic doReset;
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask

  task automatic unlock;
    axiWr(FWLG_OFS_GATE, {24'h0, FWLG_KEY_FIRST});
    gateIs(FWLG_FIRST_KEY);
    axiWr(FWLG_OFS_GATE, {24'h0, FWLG_KEY_SECOND});
    gateIs(FWLG_UNLOCKED);
  endtask

  // Returns {toData, write, erase, errorReset} seen one cycle after the move
  task automatic flashOp(input logic [1:0] ctl, input logic mon, output logic [3:0] g);
    logic [15:0] a;
    seed = lfsr(seed);
    a = seed[15:0];
    supplyMonOn <= mon;
    supplyMonReset <= mon;
    axiWr(FWLG_OFS_CTRL, {30'h0, ctl});
    @(posedge clock);
    moveReq <= {1'b1, a, seed[23:16]};
    @(posedge clock);
    moveReq <= '0;
    #1;
    g = {moveToData, flashCmd.write, flashCmd.erase, flashErrReset};
    if (g[2] || g[1])
    begin
      chk({16'h0, flashCmd.addr}, {16'h0, a});
      if (g[2])
        chk({24'h0, flashCmd.data}, {24'h0, seed[23:16]});
      @(posedge clock);
      flashDone <= 1'b1;
      @(posedge clock);
      flashDone <= 1'b0;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    failCount++;
    $display("wrong value at %0t: watchdog expired", $time);
    finalReport;
  end

  initial
  begin
    doReset;
    gateIs(FWLG_LOCKED);
    // Unmapped offsets answer with an error and leave the gate alone
    axiRd(4'h2, rd);
    chk(rd, 32'h0);
    chk({30'h0, lastResp}, 32'h2);
    axiWr(4'h2, 32'hff);
    chk({30'h0, lastResp}, 32'h2);
    gateIs(FWLG_LOCKED);
    axiWr(FWLG_OFS_MASK, 32'h7);
    chk({30'h0, lastResp}, 32'h0);
    unlock;
    flashOp(2'h1, 1'b1, got);
    chk({28'h0, got}, 32'h4);
    gateIs(FWLG_LOCKED);
    axiRd(FWLG_OFS_STAT, rd);
    chk(rd & 32'h1, 32'h1);
    irqIs(1'b1);
    axiWr(FWLG_OFS_STAT, 32'h1);
    irqIs(1'b0);
    unlock;
    flashOp(2'h3, 1'b1, got);
    chk({28'h0, got}, 32'h2);
    flashOp(2'h0, 1'b1, got);
    chk({28'h0, got}, 32'h8);
    gateIs(FWLG_LOCKED);
    unlock;
    flashOp(2'h1, 1'b0, got);
    chk({28'h0, got}, 32'h1);
    doReset;
    axiWr(FWLG_OFS_MASK, 32'h2);
    flashOp(2'h1, 1'b1, got);
    chk({28'h0, got}, 32'h0);
    gateIs(FWLG_DISABLED);
    irqIs(1'b1);
    axiWr(FWLG_OFS_MASK, 32'h0);
    irqIs(1'b0);
    axiWr(FWLG_OFS_GATE, {24'h0, FWLG_KEY_FIRST});
    gateIs(FWLG_DISABLED);
    doReset;
    gateIs(FWLG_LOCKED);
    // Even passes lead with the right first key, early passes with the right second
    for (int i = 0; i < 8; i++)
    begin
      doReset;
      s = FWLG_LOCKED;
      repeat (3)
      begin
        seed = lfsr(seed);
        k = seed[7:0];
        if (i % 2 == 0 && s == FWLG_LOCKED) k = FWLG_KEY_FIRST;
        if (i < 4 && s == FWLG_FIRST_KEY) k = FWLG_KEY_SECOND;
        axiWr(FWLG_OFS_GATE, {24'h0, k});
        s = nextLock(s, k);
        gateIs(s);
      end
    end
    finalReport;
  end
endmodule
